// ### design/liu_regs_pkg.sv
package liu_regs_pkg;

  // ==========================================================================
  // Channel decode
  // ==========================================================================
  localparam int CHANNELS = 4;
  localparam logic [7:0] CHANNEL_STRIDE = 8'h40;
  localparam logic [5:0] OFS_EVENT_FLAGS_A = 6'h16;
  localparam logic [5:0] OFS_EVENT_FLAGS_B = 6'h17;
  localparam logic [5:0] OFS_ERROR_COUNT_LOW = 6'h18;
  localparam logic [5:0] OFS_ERROR_COUNT_HIGH = 6'h19;
  localparam logic [5:0] OFS_LINE_TERMINATION_SELECT = 6'h1A;

  // ==========================================================================
  // Reset values and fields
  // ==========================================================================
  localparam logic [7:0] EVENT_FLAGS_RESET = 8'h00;
  localparam logic [15:0] ERROR_COUNT_RESET = 16'h0000;
  localparam logic [5:0] TERMINATION_RESET = 6'h00;
  localparam int TX_TERM_LSB = 3;
  localparam int RX_TERM_LSB = 0;
  localparam int TERM_WIDTH = 3;

  // Termination codes
  localparam logic [2:0] TERM_75_OHM = 3'h0;
  localparam logic [2:0] TERM_120_OHM = 3'h1;
  localparam logic [2:0] TERM_100_OHM = 3'h2;
  localparam logic [2:0] TERM_110_OHM = 3'h3;

  typedef enum logic [2:0] {
    IMP_75,
    IMP_120,
    IMP_100,
    IMP_110,
    IMP_EXTERNAL
  } impedance_t;

endpackage : liu_regs_pkg

// ### design/liu_interrupt_counter_termination_regs.sv
// What this block does
// R1 - Reading event register A returns its flags then clears all but events arriving with the read.
// R2 - Reading event register B clears its flags and drops their interrupt request.
// R3 - Four identical channel copies, decoded at bases 0x40 apart.
// R4 - Event A bit 7 latches on equalizer out-of-range event.
// R5 - Event A bits 6 and 5 latch on loopback activate and deactivate codes.
// R6 - Event A bit 4 latches on pattern synchronisation status event.
// R7 - Event A bit 3 latches on transmit clock loss event.
// R8 - Event A bit 2 latches on line driver failure event.
// R9 - Event A bit 1 latches on alarm indication event.
// R10 - Event A bit 0 latches on loss of signal event.
// R11 - Event B bit 7 latches on waveform amplitude overflow.
// R12 - Event B bits 6 and 5 latch on jitter buffer overflow and underflow.
// R13 - Event B bit 4 latches on pattern bit error.
// R14 - Event B bit 3 latches on excess zeros.
// R15 - Event B bit 2 latches on code violation.
// R16 - Event B bit 1 latches on each one-second tick.
// R17 - Event B bit 0 latches on error counter overflow.
// R18 - Error count low byte read-only, bit 0 is LSB, resets to zero; the block reads it live from error_count_in and never resets it.
// R19 - Error count high byte at next offset, read-only, bit 7 is MSB.
// R20 - Transmit termination bits 5:3 select 75, 120, 100 or 110 ohm internally.
// R21 - Transmit code 1xx selects external resistors, valid in E1 mode only.
// R22 - Receive termination bits 2:0 use the same codes, 1xx external.
// R23 - Unmasked sources set flags on rising edge, or any change with edge select.
// R24 - An event arriving with a clearing read stays latched for the next read.
module liu_interrupt_counter_termination_regs #(
  parameter int CHANNELS = liu_regs_pkg::CHANNELS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [CHANNELS*8-1:0] status_a,
  input wire logic [CHANNELS*8-1:0] status_b,
  input wire logic [CHANNELS*8-1:0] mask_a,
  input wire logic [CHANNELS*8-1:0] mask_b,
  input wire logic [CHANNELS*8-1:0] edge_any_a,
  input wire logic [CHANNELS*8-1:0] edge_any_b,
  input wire logic [CHANNELS*16-1:0] error_count_in,
  input wire logic [CHANNELS-1:0] e1_mode,
  output logic [7:0] host_rdata,
  output logic [CHANNELS-1:0] irq_a,
  output logic [CHANNELS-1:0] irq_b,
  output logic [CHANNELS*3-1:0] tx_impedance,
  output logic [CHANNELS*3-1:0] rx_impedance
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // Two address bits select the channel, so four is the most served
  if (CHANNELS < 1 || CHANNELS > liu_regs_pkg::CHANNELS) begin : g_bad_channels
    $error("CHANNELS must lie between 1 and 4");
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [7:0] edge_events(
    input logic [7:0] now,
    input logic [7:0] prev,
    input logic [7:0] mask,
    input logic [7:0] any_change
  );
    logic [7:0] rise;
    logic [7:0] change;
    rise = now & ~prev;
    change = now ^ prev;
    edge_events = ~mask & ((any_change & change) | (~any_change & rise)); // R23
  endfunction : edge_events

  function automatic logic [2:0] decode_impedance(
    input logic [2:0] code,
    input logic allow_external
  );
    logic [2:0] imp;
    imp = 3'(liu_regs_pkg::IMP_75);
    case (code)
      liu_regs_pkg::TERM_75_OHM: imp = 3'(liu_regs_pkg::IMP_75); // R20
      liu_regs_pkg::TERM_120_OHM: imp = 3'(liu_regs_pkg::IMP_120); // R20
      liu_regs_pkg::TERM_100_OHM: imp = 3'(liu_regs_pkg::IMP_100); // R20
      liu_regs_pkg::TERM_110_OHM: imp = 3'(liu_regs_pkg::IMP_110); // R20
      default: begin
        // Outside E1 the line needs no resistors; fall back to internal 75
        if (allow_external) begin
          imp = 3'(liu_regs_pkg::IMP_EXTERNAL); // R21
        end else begin
          imp = 3'(liu_regs_pkg::IMP_75);
        end
      end
    endcase
    decode_impedance = imp;
  endfunction : decode_impedance

  // ==========================================================================
  // Address decode
  // ==========================================================================
  logic [1:0] sel_channel;
  logic [5:0] sel_offset;
  logic sel_valid;
  assign sel_channel = host_addr[7:6]; // R3
  assign sel_offset = host_addr[5:0]; // R3
  assign sel_valid = 32'(sel_channel) < CHANNELS;

  // ==========================================================================
  // Per-channel state
  // ==========================================================================
  logic [7:0] flags_a_reg [CHANNELS];
  logic [7:0] flags_b_reg [CHANNELS];
  logic [7:0] prev_a_reg [CHANNELS];
  logic [7:0] prev_b_reg [CHANNELS];
  logic [5:0] term_reg [CHANNELS];
  logic [7:0] count_high_hold_reg [CHANNELS];

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_channel
    logic here;
    logic [7:0] ev_a;
    logic [7:0] ev_b;
    logic [15:0] count;
    assign here = sel_valid && (32'(sel_channel) == ch);
    assign count = error_count_in[ch*16 +: 16];
    assign ev_a = edge_events(status_a[ch*8 +: 8], prev_a_reg[ch], mask_a[ch*8 +: 8],
                              edge_any_a[ch*8 +: 8]); // R4 R5 R6 R7 R8 R9 R10
    assign ev_b = edge_events(status_b[ch*8 +: 8], prev_b_reg[ch], mask_b[ch*8 +: 8],
                              edge_any_b[ch*8 +: 8]); // R11 R12 R13 R14 R15 R16 R17

    // Status history for edge detection
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        prev_a_reg[ch] <= liu_regs_pkg::EVENT_FLAGS_RESET;
        prev_b_reg[ch] <= liu_regs_pkg::EVENT_FLAGS_RESET;
      end else begin
        prev_a_reg[ch] <= status_a[ch*8 +: 8];
        prev_b_reg[ch] <= status_b[ch*8 +: 8];
      end
    end

    // Event register A: new events win over the clearing read
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        flags_a_reg[ch] <= liu_regs_pkg::EVENT_FLAGS_RESET;
      end else if (host_rd && here && sel_offset == liu_regs_pkg::OFS_EVENT_FLAGS_A) begin
        flags_a_reg[ch] <= ev_a; // R1 R24
      end else begin
        flags_a_reg[ch] <= flags_a_reg[ch] | ev_a;
      end
    end

    // Event register B
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        flags_b_reg[ch] <= liu_regs_pkg::EVENT_FLAGS_RESET;
      end else if (host_rd && here && sel_offset == liu_regs_pkg::OFS_EVENT_FLAGS_B) begin
        flags_b_reg[ch] <= ev_b; // R2 R24
      end else begin
        flags_b_reg[ch] <= flags_b_reg[ch] | ev_b;
      end
    end

    // Interrupt requests follow the latched flags
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        irq_a[ch] <= 1'b0;
        irq_b[ch] <= 1'b0;
      end else begin
        irq_a[ch] <= |flags_a_reg[ch];
        irq_b[ch] <= |flags_b_reg[ch]; // R2
      end
    end

    // High byte frozen when low byte is read so a 16-bit read is coherent
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        count_high_hold_reg[ch] <= liu_regs_pkg::ERROR_COUNT_RESET[15:8];
      end else if (host_rd && here && sel_offset == liu_regs_pkg::OFS_ERROR_COUNT_LOW) begin
        count_high_hold_reg[ch] <= count[15:8]; // R19
      end
    end

    // Termination register; reserved bits 7:6 are not stored
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        term_reg[ch] <= liu_regs_pkg::TERMINATION_RESET;
      end else if (host_wr && here &&
                   sel_offset == liu_regs_pkg::OFS_LINE_TERMINATION_SELECT) begin
        term_reg[ch] <= host_wdata[5:0]; // R20 R22
      end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        tx_impedance[ch*3 +: 3] <= 3'(liu_regs_pkg::IMP_75);
        rx_impedance[ch*3 +: 3] <= 3'(liu_regs_pkg::IMP_75);
      end else begin
        tx_impedance[ch*3 +: 3] <= decode_impedance(
          term_reg[ch][liu_regs_pkg::TX_TERM_LSB +: liu_regs_pkg::TERM_WIDTH],
          e1_mode[ch]); // R21
        rx_impedance[ch*3 +: 3] <= decode_impedance(
          term_reg[ch][liu_regs_pkg::RX_TERM_LSB +: liu_regs_pkg::TERM_WIDTH],
          1'b1); // R22
      end
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  logic [7:0] rdata_next;
  logic [15:0] count_sel;
  always_comb begin
    rdata_next = 8'h00;
    count_sel = 16'h0000;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      if (sel_valid && 32'(sel_channel) == ch) begin
        count_sel = error_count_in[ch*16 +: 16];
        case (sel_offset)
          liu_regs_pkg::OFS_EVENT_FLAGS_A: rdata_next = flags_a_reg[ch]; // R1
          liu_regs_pkg::OFS_EVENT_FLAGS_B: rdata_next = flags_b_reg[ch]; // R2
          liu_regs_pkg::OFS_ERROR_COUNT_LOW: rdata_next = count_sel[7:0]; // R18
          liu_regs_pkg::OFS_ERROR_COUNT_HIGH: rdata_next = count_high_hold_reg[ch]; // R19
          liu_regs_pkg::OFS_LINE_TERMINATION_SELECT: rdata_next = {2'b00, term_reg[ch]};
          default: rdata_next = 8'h00;
        endcase
      end
    end
  end

  // Data registered on the read strobe and held until the next read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      host_rdata <= rdata_next;
    end
  end

endmodule : liu_interrupt_counter_termination_regs

// ### dv/liu_regs_props.sv
module liu_regs_props #(
  parameter int CHANNELS = 4
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [CHANNELS*8-1:0] status_a,
  input wire logic [CHANNELS*8-1:0] status_b,
  input wire logic [CHANNELS*8-1:0] mask_a,
  input wire logic [CHANNELS*16-1:0] error_count_in,
  input wire logic [CHANNELS-1:0] e1_mode,
  input wire logic [7:0] host_rdata,
  input wire logic [CHANNELS-1:0] irq_a,
  input wire logic [CHANNELS-1:0] irq_b,
  input wire logic [CHANNELS*3-1:0] tx_impedance,
  input wire logic [CHANNELS*3-1:0] rx_impedance
);
  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_event_raises_irq: assert property ($rose(status_a[0]) && !mask_a[0] |-> ##[1:2] irq_a[0])
    else $error("irq a not raised");
  // Stable sources only, a fresh event may legally keep the request up
  chk_read_clears_a: assert property (host_rd && host_addr == 8'h16
    && status_a[7:0] == $past(status_a[7:0]) |-> ##2 !irq_a[0]) else $error("flags a kept");
  chk_read_clears_b: assert property (host_rd && host_addr == 8'h57
    && status_b[15:8] == $past(status_b[15:8]) |-> ##2 !irq_b[1]) else $error("flags b kept");
  chk_count_low_byte: assert property (host_rd && host_addr == 8'h18
    |=> host_rdata == $past(error_count_in[7:0])) else $error("low byte wrong");
  chk_count_high_byte: assert property (host_rd && host_addr == 8'h18 ##2 host_rd
    && host_addr == 8'h19 |=> host_rdata == $past(error_count_in[15:8], 3))
    else $error("high byte wrong");
  chk_rx_term_decode: assert property (host_wr && host_addr == 8'h1A |-> ##2
    rx_impedance[2:0] == ($past(host_wdata[2], 2) ? 3'h4 : $past(host_wdata[2:0], 2)))
    else $error("rx impedance wrong");
  chk_tx_term_internal: assert property (host_wr && host_addr == 8'h1A && !host_wdata[5]
    |-> ##2 tx_impedance[2:0] == $past(host_wdata[5:3], 2)) else $error("tx internal wrong");
  chk_tx_term_external: assert property (host_wr && host_addr == 8'h1A && host_wdata[5]
    |-> ##2 tx_impedance[2:0] == ($past(e1_mode[0]) ? 3'h4 : 3'h0))
    else $error("tx external wrong");
  chk_unmapped_reads_zero: assert property (host_rd
    && !(host_addr[5:0] inside {[6'h16:6'h1A]}) |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (irq_a[0] && irq_b[0]);
  cover property (host_rd && host_addr == 8'h57 && irq_b[1]);
  cover property (host_wr && host_addr == 8'h1A && host_wdata[5] && e1_mode[0]);
endmodule : liu_regs_props

bind liu_interrupt_counter_termination_regs liu_regs_props #(.CHANNELS(CHANNELS)) props_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .host_rd(host_rd), .host_wr(host_wr),
  .host_addr(host_addr), .host_wdata(host_wdata), .status_a(status_a), .status_b(status_b),
  .mask_a(mask_a), .error_count_in(error_count_in), .e1_mode(e1_mode),
  .host_rdata(host_rdata), .irq_a(irq_a), .irq_b(irq_b),
  .tx_impedance(tx_impedance), .rx_impedance(rx_impedance));

// ### dv/liu_interrupt_counter_termination_regs_bench.sv
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end

module liu_interrupt_counter_termination_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CH = 4;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic host_rd = 1'b0;
  logic host_wr = 1'b0;
  logic [7:0] host_addr = 8'h00;
  logic [7:0] host_wdata = 8'h00;
  logic [CH*8-1:0] status_a = '0;
  logic [CH*8-1:0] status_b = '0;
  logic [CH*8-1:0] mask_a = '0;
  logic [CH*8-1:0] mask_b = '0;
  logic [CH*8-1:0] edge_any_a = '0;
  logic [CH*8-1:0] edge_any_b = '0;
  logic [CH*16-1:0] error_count_in = '0;
  logic [CH-1:0] e1_mode = '0;
  logic [7:0] host_rdata;
  logic [CH-1:0] irq_a;
  logic [CH-1:0] irq_b;
  logic [CH*3-1:0] tx_impedance;
  logic [CH*3-1:0] rx_impedance;
  logic [2:0] t;
  logic [2:0] r;
  int errors = 0;
  int cmp_count = 0;

  always #4 clk_sys = ~clk_sys;

  liu_interrupt_counter_termination_regs #(.CHANNELS(CH)) liu_interrupt_counter_termination_regs_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .host_rd(host_rd), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata), .status_a(status_a), .status_b(status_b),
    .mask_a(mask_a), .mask_b(mask_b), .edge_any_a(edge_any_a), .edge_any_b(edge_any_b),
    .error_count_in(error_count_in), .e1_mode(e1_mode), .host_rdata(host_rdata),
    .irq_a(irq_a), .irq_b(irq_b), .tx_impedance(tx_impedance), .rx_impedance(rx_impedance));

  // ==========================================================================
  // Host access
  // ==========================================================================
  task automatic summarize;
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge clk_sys);
    host_wr = 1'b0;
  endtask : wr

  // Strobe dropped a full cycle later, so each call is exactly one clearing read
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(negedge clk_sys);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge clk_sys);
    host_rd = 1'b0;
    `CHK(n, e, host_rdata)
  endtask : rd

  task automatic ev(input int c, input int b, input bit isb);
    logic [7:0] ad;
    ad = {c[1:0], isb ? 6'h17 : 6'h16};
    if (isb) status_b[c*8+b] = 1'b1;
    else status_a[c*8+b] = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK("irq_up", 1'b1, isb ? irq_b[c] : irq_a[c])
    rd(ad, 8'h01 << b, "event_flags");
    rd(ad, 8'h00, "event_cleared");
    `CHK("irq_down", 1'b0, isb ? irq_b[c] : irq_a[c])
    status_a[c*8+b] = 1'b0;
    status_b[c*8+b] = 1'b0;
  endtask : ev

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    for (int a = 22; a < 27; a++) rd(8'(a), 8'h00, "reset_value");
    `CHK("impedance_reset", 24'h000000, {tx_impedance, rx_impedance})
    for (int c = 0; c < CH; c++) begin
      for (int b = 0; b < 8; b++) begin
        ev(c, b, 1'b0);
        ev(c, b, 1'b1);
      end
    end
    mask_a[7:0] = 8'hFF;
    status_a[0] = 1'b1;
    rd(8'h16, 8'h00, "masked");
    status_a[0] = 1'b0;
    mask_a[7:0] = 8'h00;
    edge_any_b[19] = 1'b1;
    status_b[19] = 1'b1;
    rd(8'h97, 8'h08, "rise_any");
    status_b[19] = 1'b0;
    rd(8'h97, 8'h08, "fall_any");
    edge_any_b[19] = 1'b0;
    @(negedge clk_sys);
    status_b[0] = 1'b1;
    host_rd = 1'b1;
    host_addr = 8'h17;
    @(negedge clk_sys);
    host_rd = 1'b0;
    rd(8'h17, 8'h01, "set_wins");
    error_count_in[31:16] = 16'hBEEF;
    rd(8'h58, 8'hEF, "count_low");
    error_count_in[31:16] = 16'h1234;
    rd(8'h59, 8'hBE, "count_high");
    wr(8'h58, 8'h77);
    rd(8'h58, 8'h34, "count_read_only");
    error_count_in[15:0] = 16'hA55A;
    rd(8'h18, 8'h5A, "count_low_ch0");
    rd(8'h19, 8'hA5, "count_high_ch0");
    rd(8'h3F, 8'h00, "unmapped");
    for (int e = 0; e < 2; e++) begin
      e1_mode[0] = e[0];
      for (int k = 0; k < 8; k++) begin
        t = 3'(k);
        r = 3'(7 - k);
        wr(8'h1A, {2'b11, t, r});
        rd(8'h1A, {2'b00, t, r}, "termination");
        `CHK("tx_imp", t[2] ? (e[0] ? 3'h4 : 3'h0) : t, tx_impedance[2:0])
        `CHK("rx_imp", r[2] ? 3'h4 : r, rx_impedance[2:0])
      end
    end
    wr(8'hDA, 8'h06);
    rd(8'h1A, 8'h38, "term_other_channel");
    `CHK("rx_imp_ch3", 3'h4, rx_impedance[11:9])
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    summarize();
  end
endmodule : liu_interrupt_counter_termination_regs_bench
